// [mc_global_defines.vh]
// Constants for the multichannel global parameter bank.
// Assumes byte addressing with one aligned 32-bit word per register index.
`ifndef MC_GLOBAL_DEFINES_VH
`define MC_GLOBAL_DEFINES_VH

// Register indices; byte address is four times the index
`define IDX_MAX_RX_BUF_LEN 8'h06
`define IDX_TX_SLOT_PTR 8'h08
`define IDX_RX_CUR_SLOT_PTR 8'h0a
`define IDX_GLB_RX_THRESH 8'h0c
`define IDX_GLB_RX_DOWNCNT 8'h0e
`define IDX_INTQ_BASE 8'h10
`define IDX_INTQ_NEXT 8'h14
`define IDX_IRQ_STATUS 8'h20
`define IDX_IRQ_MASK 8'h21
`define IDX_CTRL 8'h22

// Reset values
`define RST_TX_SLOT_PTR 16'h0060
`define RST_RX_CUR_SLOT_PTR 16'h0020
`define RST_MAX_RX_BUF_LEN 16'h0000
`define RST_THRESH 16'h0001
`define RST_QUEUE_LEN 16'h0040

// Receive slot pointer step in bytes, one 16-bit table entry
`define RX_SLOT_STEP 16'h0002

// Interrupt status bit positions
`define IRQ_GLOBAL 0
`define IRQ_BUF_FULL 1
`define IRQ_EXCEPTION 2
`define IRQ_BITS 3

// Control bit positions
`define CTRL_HDLC 0

// Interrupt queue entry size in bytes
`define INTQ_ENTRY_BYTES 32'h0000_0004

`endif

// [multichannel_global_params.v]
// Global parameter bank shared by all logical channels of one serial channel.
// Assumes a one-cycle register port and event strobes from the channel engine.
`timescale 1ns/1ps
`include "mc_global_defines.vh"

module multichannel_global_params (
	// Clock and reset
	input wire i_core_clk,
	input wire i_reset,
	// Register port
	input wire [7:0] i_addr,
	input wire [31:0] i_wdata,
	input wire i_wr,
	input wire i_rd,
	output reg [31:0] o_rdata,
	// Receive byte stream of the current channel
	input wire i_rx_byte_valid,
	input wire i_rx_frame_end,
	input wire i_rx_non_octet,
	input wire i_rx_slot_done,
	input wire i_tx_slot_done,
	// Exception requests for the interrupt queue
	input wire i_exception,
	input wire [31:0] i_exception_info,
	input wire [15:0] i_dpr_base,
	// Buffer and queue write outputs
	output reg o_buf_next,
	output reg o_residual_word_wr,
	output reg o_intq_wr,
	output reg [31:0] o_intq_addr,
	output reg [31:0] o_intq_data,
	output reg [15:0] o_tx_table_addr,
	output reg [15:0] o_rx_slot_addr,
	// Interrupt
	output reg o_irq
);

	reg [15:0] max_rx_buffer_length_r;
	reg [15:0] tx_slot_table_pointer_r;
	reg [15:0] rx_current_slot_pointer_r;
	reg [15:0] global_rx_frame_threshold_r;
	reg [15:0] global_rx_frame_downcount_r;
	reg [31:0] interrupt_queue_base_r;
	reg [31:0] interrupt_queue_next_r;
	reg [15:0] queue_len_r;
	reg [15:0] queue_idx_r;
	reg [`IRQ_BITS-1:0] irq_status_r;
	reg [`IRQ_BITS-1:0] irq_mask_r;
	reg [`IRQ_BITS-1:0] irq_event;
	reg hdlc_mode_r;
	reg [15:0] buf_count_r;
	reg global_hit;
	reg frame_evt;
	reg buf_full;
	reg [31:0] rdata_nxt;
	reg [1:0] q_src;
	// Host write selects and next values of the hardware-updated registers
	reg wr_max_len;
	reg wr_tx_ptr;
	reg wr_rx_ptr;
	reg wr_thresh;
	reg wr_downcnt;
	reg wr_q_base;
	reg wr_q_next;
	reg wr_status;
	reg wr_mask;
	reg wr_ctrl;
	reg [15:0] rx_current_slot_pointer_nxt;
	reg [15:0] global_rx_frame_downcount_nxt;
	reg [15:0] queue_idx_nxt;
	reg [31:0] interrupt_queue_next_nxt;
	wire [`IRQ_BITS-1:0] irq_status_nxt;
	genvar g;

	// Threshold reached when a frame ends while the count stands at one; the count then reloads from the threshold instead of stepping to zero
	always @* begin
		frame_evt = i_rx_frame_end;
		global_hit = frame_evt && (global_rx_frame_downcount_r == 16'h0001);
		buf_full = hdlc_mode_r && i_rx_byte_valid
			&& (buf_count_r + 16'h0001 >= max_rx_buffer_length_r);
		irq_event = {`IRQ_BITS{1'b0}};
		irq_event[`IRQ_GLOBAL] = global_hit;
		irq_event[`IRQ_BUF_FULL] = buf_full;
		irq_event[`IRQ_EXCEPTION] = i_exception;
	end

	// Host write selects, one per register index
	always @* begin
		wr_max_len = i_wr && (i_addr == `IDX_MAX_RX_BUF_LEN);
		wr_tx_ptr = i_wr && (i_addr == `IDX_TX_SLOT_PTR);
		wr_rx_ptr = i_wr && (i_addr == `IDX_RX_CUR_SLOT_PTR);
		wr_thresh = i_wr && (i_addr == `IDX_GLB_RX_THRESH);
		wr_downcnt = i_wr && (i_addr == `IDX_GLB_RX_DOWNCNT);
		wr_q_base = i_wr && (i_addr == `IDX_INTQ_BASE);
		wr_q_next = i_wr && (i_addr == `IDX_INTQ_NEXT);
		wr_status = i_wr && (i_addr == `IDX_IRQ_STATUS);
		wr_mask = i_wr && (i_addr == `IDX_IRQ_MASK);
		wr_ctrl = i_wr && (i_addr == `IDX_CTRL);
	end

	// Buffer length limit, host owned
	always @(posedge i_core_clk) begin
		if (i_reset)
			max_rx_buffer_length_r <= `RST_MAX_RX_BUF_LEN;
		else if (wr_max_len)
			max_rx_buffer_length_r <= i_wdata[15:0];
	end

	// Transmit table pointer, may be moved onto the receive table
	always @(posedge i_core_clk) begin
		if (i_reset)
			tx_slot_table_pointer_r <= `RST_TX_SLOT_PTR;
		else if (wr_tx_ptr)
			tx_slot_table_pointer_r <= i_wdata[15:0];
	end

	// Threshold; a running change takes effect at the next reload
	always @(posedge i_core_clk) begin
		if (i_reset)
			global_rx_frame_threshold_r <= `RST_THRESH;
		else if (wr_thresh)
			global_rx_frame_threshold_r <= i_wdata[15:0];
	end

	// Queue base address, host owned
	always @(posedge i_core_clk) begin
		if (i_reset)
			interrupt_queue_base_r <= 32'h0000_0000;
		else if (wr_q_base)
			interrupt_queue_base_r <= i_wdata;
	end

	// Interrupt mask, same layout as status
	always @(posedge i_core_clk) begin
		if (i_reset)
			irq_mask_r <= {`IRQ_BITS{1'b0}};
		else if (wr_mask)
			irq_mask_r <= i_wdata[`IRQ_BITS-1:0];
	end

	// Control: HDLC mode bit and queue length in entries
	always @(posedge i_core_clk) begin
		if (i_reset) begin
			hdlc_mode_r <= 1'b0;
			queue_len_r <= `RST_QUEUE_LEN;
		end else if (wr_ctrl) begin
			hdlc_mode_r <= i_wdata[`CTRL_HDLC];
			queue_len_r <= i_wdata[31:16];
		end
	end

	// Receive slot pointer: slot completion beats a host write
	always @* begin
		if (i_rx_slot_done)
			rx_current_slot_pointer_nxt = rx_current_slot_pointer_r + `RX_SLOT_STEP;
		else if (wr_rx_ptr)
			rx_current_slot_pointer_nxt = i_wdata[15:0];
		else
			rx_current_slot_pointer_nxt = rx_current_slot_pointer_r;
	end

	// Receive slot pointer register
	always @(posedge i_core_clk) begin
		if (i_reset)
			rx_current_slot_pointer_r <= `RST_RX_CUR_SLOT_PTR;
		else
			rx_current_slot_pointer_r <= rx_current_slot_pointer_nxt;
	end

	// Frame down-counter: reload on a hit, else count frames, else host
	always @* begin
		if (global_hit)
			global_rx_frame_downcount_nxt = global_rx_frame_threshold_r;
		else if (frame_evt)
			global_rx_frame_downcount_nxt = global_rx_frame_downcount_r - 16'h0001;
		else if (wr_downcnt)
			global_rx_frame_downcount_nxt = i_wdata[15:0];
		else
			global_rx_frame_downcount_nxt = global_rx_frame_downcount_r;
	end

	// Frame down-counter register; other receive events never touch it
	always @(posedge i_core_clk) begin
		if (i_reset)
			global_rx_frame_downcount_r <= `RST_THRESH;
		else
			global_rx_frame_downcount_r <= global_rx_frame_downcount_nxt;
	end

	// Queue pointer: one step per entry, back to the base after the last
	always @* begin
		queue_idx_nxt = queue_idx_r;
		interrupt_queue_next_nxt = interrupt_queue_next_r;
		if (q_src != 2'b00) begin
			if (queue_idx_r + 16'h0001 >= queue_len_r) begin
				queue_idx_nxt = 16'h0000;
				interrupt_queue_next_nxt = interrupt_queue_base_r;
			end else begin
				queue_idx_nxt = queue_idx_r + 16'h0001;
				interrupt_queue_next_nxt = interrupt_queue_next_r + `INTQ_ENTRY_BYTES;
			end
		end else if (wr_q_next) begin
			queue_idx_nxt = 16'h0000;
			interrupt_queue_next_nxt = i_wdata;
		end
	end

	// Queue pointer and entry index registers
	always @(posedge i_core_clk) begin
		if (i_reset) begin
			queue_idx_r <= 16'h0000;
			interrupt_queue_next_r <= 32'h0000_0000;
		end else begin
			queue_idx_r <= queue_idx_nxt;
			interrupt_queue_next_r <= interrupt_queue_next_nxt;
		end
	end

	// Sticky status per bit; a new event beats write-one-to-clear
	generate
		for (g = 0; g < `IRQ_BITS; g = g + 1) begin : gen_status
			assign irq_status_nxt[g] = irq_event[g]
				| (irq_status_r[g] & ~(wr_status & i_wdata[g]));
		end
	endgenerate

	// Status register
	always @(posedge i_core_clk) begin
		if (i_reset)
			irq_status_r <= {`IRQ_BITS{1'b0}};
		else
			irq_status_r <= irq_status_nxt;
	end

	// Queue source: frame event, else exception
	always @* begin
		if (frame_evt)
			q_src = 2'b01;
		else if (i_exception)
			q_src = 2'b10;
		else
			q_src = 2'b00;
	end

	// Receive buffer fill counter
	always @(posedge i_core_clk) begin
		if (i_reset)
			buf_count_r <= 16'h0000;
		else if (i_rx_frame_end || buf_full)
			buf_count_r <= 16'h0000;
		else if (i_rx_byte_valid && hdlc_mode_r)
			buf_count_r <= buf_count_r + 16'h0001;
	end

	// Read mux
	always @* begin
		rdata_nxt = 32'h0000_0000;
		case (i_addr)
			`IDX_MAX_RX_BUF_LEN: rdata_nxt = {16'h0000, max_rx_buffer_length_r};
			`IDX_TX_SLOT_PTR: rdata_nxt = {16'h0000, tx_slot_table_pointer_r};
			`IDX_RX_CUR_SLOT_PTR: rdata_nxt = {16'h0000, rx_current_slot_pointer_r};
			`IDX_GLB_RX_THRESH: rdata_nxt = {16'h0000, global_rx_frame_threshold_r};
			`IDX_GLB_RX_DOWNCNT: rdata_nxt = {16'h0000, global_rx_frame_downcount_r};
			`IDX_INTQ_BASE: rdata_nxt = interrupt_queue_base_r;
			`IDX_INTQ_NEXT: rdata_nxt = interrupt_queue_next_r;
			`IDX_IRQ_STATUS: rdata_nxt = {29'h0000_0000, irq_status_r};
			`IDX_IRQ_MASK: rdata_nxt = {29'h0000_0000, irq_mask_r};
			`IDX_CTRL: rdata_nxt = {queue_len_r, 15'h0000, hdlc_mode_r};
			default: rdata_nxt = 32'h0000_0000;
		endcase
	end

	// Registered outputs
	always @(posedge i_core_clk) begin
		if (i_reset) begin
			o_rdata <= 32'h0000_0000;
			o_buf_next <= 1'b0;
			o_residual_word_wr <= 1'b0;
			o_intq_wr <= 1'b0;
			o_intq_addr <= 32'h0000_0000;
			o_intq_data <= 32'h0000_0000;
			o_tx_table_addr <= 16'h0000;
			o_rx_slot_addr <= 16'h0000;
			o_irq <= 1'b0;
		end else begin
			o_rdata <= i_rd ? rdata_nxt : 32'h0000_0000;
			o_buf_next <= buf_full && !i_rx_frame_end;
			o_residual_word_wr <= i_rx_frame_end && i_rx_non_octet && hdlc_mode_r;
			o_intq_wr <= (q_src != 2'b00);
			o_intq_addr <= interrupt_queue_next_r;
			o_intq_data <= frame_evt ? 32'h0000_0001 : i_exception_info;
			o_tx_table_addr <= i_dpr_base + tx_slot_table_pointer_r;
			o_rx_slot_addr <= i_dpr_base + rx_current_slot_pointer_r;
			o_irq <= |((irq_status_r | irq_event) & irq_mask_r);
		end
	end

endmodule // multichannel_global_params

// [mc_global_chk.sv]
// Port checker for the global parameter bank.
// Assumes it is bound to the bank and sees only its ports.
`timescale 1ns/1ps
module mc_global_chk (
	// Clock, reset and register port
	input wire i_core_clk,
	input wire i_reset,
	input wire i_wr,
	input wire i_rd,
	input wire [31:0] o_rdata,
	// Events and outputs under watch
	input wire i_rx_byte_valid,
	input wire i_rx_frame_end,
	input wire i_rx_non_octet,
	input wire i_exception,
	input wire [31:0] i_exception_info,
	input wire o_buf_next,
	input wire o_residual_word_wr,
	input wire o_intq_wr,
	input wire [31:0] o_intq_data,
	input wire o_irq
);
	// All checks share the core clock and its reset
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_reset);
	frame_queued_a: assert property (i_rx_frame_end |=> o_intq_wr)
		else $error("frame end not queued");
	exc_entry_a: assert property (
		i_exception && !i_rx_frame_end |=> o_intq_wr && o_intq_data == $past(i_exception_info))
		else $error("exception entry wrong");
	queue_cause_a: assert property (o_intq_wr |-> $past(i_rx_frame_end || i_exception))
		else $error("queue write without cause");
	residual_cause_a: assert property (
		o_residual_word_wr |-> $past(i_rx_frame_end && i_rx_non_octet))
		else $error("residual word without cause");
	no_residual_a: assert property (
		i_rx_frame_end && !i_rx_non_octet |=> !o_residual_word_wr)
		else $error("residual word on aligned frame");
	buf_cause_a: assert property (o_buf_next |-> $past(i_rx_byte_valid))
		else $error("buffer switch without byte");
	irq_cause_a: assert property (
		$rose(o_irq) |-> $past(i_rx_frame_end || i_exception || i_rx_byte_valid) || $past(i_wr, 2))
		else $error("interrupt without cause");
	rdata_quiet_a: assert property (!$past(i_rd) |-> o_rdata == 32'h0000_0000)
		else $error("read data outside answer cycle");
endmodule // mc_global_chk

bind multichannel_global_params mc_global_chk u_chk (.i_core_clk, .i_reset, .i_wr, .i_rd,
	.o_rdata, .i_rx_byte_valid, .i_rx_frame_end, .i_rx_non_octet, .i_exception,
	.i_exception_info, .o_buf_next, .o_residual_word_wr, .o_intq_wr, .o_intq_data, .o_irq);

// [chan_engine.sv]
// Channel engine model issuing receive and exception strobes.
// Assumes a go level with a kind code, one strobe per cycle held.
`timescale 1ns/1ps
module chan_engine (
	// Clock and command
	input wire i_clk,
	input wire i_go,
	input wire [1:0] i_kind,
	// Event strobes
	output reg o_byte = 1'b0,
	output reg o_frame = 1'b0,
	output reg o_slot = 1'b0,
	output reg o_exc = 1'b0
);
	// One strobe per cycle of go, kind selects which
	always @(posedge i_clk) begin
		o_byte <= i_go && i_kind == 2'h0;
		o_frame <= i_go && i_kind == 2'h1;
		o_slot <= i_go && i_kind == 2'h2;
		o_exc <= i_go && i_kind == 2'h3;
	end
endmodule // chan_engine

// [tb.sv]
// Self-checking bench for the global parameter bank.
// Assumes the channel engine model drives the event strobes.
`timescale 1ns/1ps
`include "mc_global_defines.vh"
module tb;
	reg clk = 1'b0;
	reg rst = 1'b1;
	reg [7:0] addr = 8'h00;
	reg [31:0] wd = 32'h0000_0000;
	reg wr = 1'b0;
	reg rd = 1'b0;
	reg go = 1'b0;
	reg [1:0] kind = 2'h0;
	reg nonoct = 1'b0;
	reg [31:0] info = 32'h0000_0000;
	reg [15:0] dpr = 16'h0000;
	wire bv, fe, sd, ex, bn, rw, qw, irq;
	wire [31:0] rdata, qa, qd;
	wire [15:0] txa, rxa;
	integer err_count = 0;
	integer num_checks = 0;
	integer cyc = 0;
	integer nbn = 0;
	integer nrw = 0;
	reg [31:0] last_qa = 32'h0000_0000;
	reg [31:0] last_qd = 32'h0000_0000;
	multichannel_global_params u_dut (.i_core_clk(clk), .i_reset(rst), .i_addr(addr),
		.i_wdata(wd), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_rx_byte_valid(bv),
		.i_rx_frame_end(fe), .i_rx_non_octet(nonoct), .i_rx_slot_done(sd),
		.i_tx_slot_done(1'b0), .i_exception(ex), .i_exception_info(info),
		.i_dpr_base(dpr), .o_buf_next(bn), .o_residual_word_wr(rw), .o_intq_wr(qw),
		.o_intq_addr(qa), .o_intq_data(qd), .o_tx_table_addr(txa), .o_rx_slot_addr(rxa),
		.o_irq(irq));
	chan_engine u_eng (.i_clk(clk), .i_go(go), .i_kind(kind), .o_byte(bv), .o_frame(fe),
		.o_slot(sd), .o_exc(ex));
	// Core clock, 100 ns period
	initial forever #50 clk = ~clk;
	task chk(input [31:0] seen, input [31:0] exp);
		begin
			num_checks = num_checks + 1;
			if (seen !== exp) begin
				err_count = err_count + 1;
				$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task wreg(input [7:0] a, input [31:0] d);
		begin
			@(posedge clk);
			addr <= a;
			wd <= d;
			wr <= 1'b1;
			@(posedge clk);
			wr <= 1'b0;
		end
	endtask
	task rreg(input [7:0] a, input [31:0] exp);
		begin
			@(posedge clk);
			addr <= a;
			rd <= 1'b1;
			@(posedge clk);
			rd <= 1'b0;
			#1 chk(rdata, exp);
		end
	endtask
	// Issue n back-to-back events of one kind, then let them settle
	task ev(input [1:0] k, input integer n);
		begin
			repeat (n) begin
				@(posedge clk);
				go <= 1'b1;
				kind <= k;
			end
			@(posedge clk);
			go <= 1'b0;
			repeat (3) @(posedge clk);
		end
	endtask
	task test_done;
		begin
			$display("checks %0d errors %0d", num_checks, err_count);
			if (err_count == 0 && num_checks > 0)
				$display("Simulation passed");
			else
				$display("Simulation failed");
			$finish;
		end
	endtask
	// Count buffer switches and residual writes; cut a hang short
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (bn)
			nbn <= nbn + 1;
		if (rw)
			nrw <= nrw + 1;
		if (qw) begin
			last_qa <= qa;
			last_qd <= qd;
		end
		if (cyc == 3000) begin
			err_count = err_count + 1;
			test_done;
		end
	end
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		rreg(`IDX_TX_SLOT_PTR, 32'h0000_0060);
		rreg(`IDX_GLB_RX_DOWNCNT, 32'h0000_0001);
		rreg(8'h30, 32'h0000_0000);
		chk(txa, 32'h0000_0060);
		// Shared table at base plus 20, offset from the RAM base
		@(posedge clk);
		dpr <= 16'h0100;
		wreg(`IDX_TX_SLOT_PTR, 32'h0000_0020);
		repeat (2) @(posedge clk);
		#1 chk(txa, 32'h0000_0120);
		rreg(`IDX_TX_SLOT_PTR, 32'h0000_0020);
		// Host set-up before interrupts are enabled
		wreg(`IDX_RX_CUR_SLOT_PTR, 32'h0000_0020);
		wreg(`IDX_INTQ_BASE, 32'h0000_1000);
		wreg(`IDX_INTQ_NEXT, 32'h0000_1000);
		wreg(`IDX_GLB_RX_THRESH, 32'h0000_0003);
		wreg(`IDX_GLB_RX_DOWNCNT, 32'h0000_0003);
		wreg(`IDX_MAX_RX_BUF_LEN, 32'h0000_0004);
		wreg(`IDX_CTRL, 32'h0040_0001);
		wreg(`IDX_IRQ_MASK, 32'h0000_0005);
		// Frames count down; slots leave the count alone
		ev(2'h1, 2);
		#1 chk(irq, 32'h0000_0000);
		ev(2'h2, 1);
		rreg(`IDX_GLB_RX_DOWNCNT, 32'h0000_0001);
		rreg(`IDX_RX_CUR_SLOT_PTR, 32'h0000_0022);
		chk(rxa, 32'h0000_0122);
		ev(2'h1, 1);
		#1 chk(irq, 32'h0000_0001);
		rreg(`IDX_GLB_RX_DOWNCNT, 32'h0000_0003);
		rreg(`IDX_INTQ_NEXT, 32'h0000_100c);
		wreg(`IDX_IRQ_STATUS, 32'h0000_0001);
		repeat (2) @(posedge clk);
		#1 chk(irq, 32'h0000_0000);
		// Threshold changed while running
		wreg(`IDX_GLB_RX_THRESH, 32'h0000_0002);
		ev(2'h1, 3);
		rreg(`IDX_GLB_RX_DOWNCNT, 32'h0000_0002);
		@(posedge clk);
		info <= 32'ha5a5_0001;
		ev(2'h3, 1);
		rreg(`IDX_INTQ_NEXT, 32'h0000_101c);
		rreg(`IDX_IRQ_STATUS, 32'h0000_0005);
		chk(last_qa, 32'h0000_1018);
		chk(last_qd, 32'ha5a5_0001);
		// Buffer limit of four bytes, then an unaligned frame end that wraps the queue
		ev(2'h0, 4);
		#1 chk(nbn, 32'h0000_0001);
		wreg(`IDX_CTRL, 32'h0008_0001);
		@(posedge clk);
		nonoct <= 1'b1;
		ev(2'h1, 1);
		#1 chk(nrw, 32'h0000_0001);
		chk(nbn, 32'h0000_0001);
		chk(last_qa, 32'h0000_101c);
		rreg(`IDX_INTQ_NEXT, 32'h0000_1000);
		// Outside HDLC mode the length limit does not apply
		wreg(`IDX_CTRL, 32'h0008_0000);
		ev(2'h0, 4);
		#1 chk(nbn, 32'h0000_0001);
		test_done;
	end
endmodule // tb
